//--- cwp_pkg.sv
package cwp_pkg;

   // APB register map (byte addresses)
   localparam logic [7:0] CWP_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CWP_ADDR_STATUS = 8'h04;
   localparam logic [7:0] CWP_ADDR_ACCESS = 8'h08;
   localparam logic [7:0] CWP_ADDR_RESULT = 8'h0C;

   // CTRL fields
   localparam int CWP_CTRL_DONE_EN = 0;
   localparam int CWP_CTRL_TRANSPARENT = 1;
   localparam int CWP_CTRL_RSVD = 2;
   localparam logic [31:0] CWP_CTRL_RESET = 32'h00000001;

   // STATUS fields
   localparam int CWP_ST_PHASE_LO = 0;
   localparam int CWP_ST_USER = 4;
   localparam int CWP_ST_PROG = 5;
   localparam int CWP_ST_BG = 6;
   localparam int CWP_ST_INIT_N = 7;
   localparam int CWP_ST_DONE_INT = 8;

   // ACCESS request fields: port[1:0], space, write, go
   localparam int CWP_ACC_PORT_LO = 0;
   localparam int CWP_ACC_SPACE = 2;
   localparam int CWP_ACC_WRITE = 3;
   localparam int CWP_ACC_GO = 4;
   localparam int CWP_ACC_MODE = 5;

   // Configuration ports
   localparam logic [1:0] CWP_PORT_SCAN = 2'h0;
   localparam logic [1:0] CWP_PORT_SPI = 2'h1;
   localparam logic [1:0] CWP_PORT_I2C = 2'h2;
   localparam logic [1:0] CWP_PORT_WB = 2'h3;

   // Memory spaces
   localparam logic CWP_SPACE_NV = 1'b0;
   localparam logic CWP_SPACE_SRAM = 1'b1;

   // Flash programming commands
   localparam logic [1:0] CWP_CMD_NONE = 2'h0;
   localparam logic [1:0] CWP_CMD_OFFLINE = 2'h1;
   localparam logic [1:0] CWP_CMD_BACKGROUND = 2'h2;
   localparam logic [1:0] CWP_CMD_REFRESH = 2'h3;

   // Flash sector select bits
   localparam int CWP_SEC_FEATURE = 0;
   localparam int CWP_SEC_CONFIG = 1;
   localparam int CWP_SEC_USER_NV = 2;

   localparam logic [31:0] CWP_RDATA_ZERO = 32'h00000000;

   typedef enum logic [2:0]
   {
      CWP_ST_INIT = 3'b000,
      CWP_ST_CONFIG = 3'b001,
      CWP_ST_WAKE1 = 3'b010,
      CWP_ST_WAKE2 = 3'b011,
      CWP_ST_WAKE3 = 3'b100,
      CWP_ST_USERMODE = 3'b101,
      CWP_ST_PROGMODE = 3'b110
   } cwp_state_e;

endpackage : cwp_pkg

//--- cwp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_sync
   import cwp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic async_in,
   output logic sync_out
);

   logic meta_q;

   // Reset to high: pins sampled here idle high
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= 1'b1;
         sync_out <= 1'b1;
      end
      else if (clk_en)
      begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : cwp_sync
`default_nettype wire

//--- cwp_access.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_access
   import cwp_pkg::*;
(
   input wire logic [1:0] port,
   input wire logic space,
   input wire logic write,
   input wire logic transparent,
   output logic granted
);

   logic nv_ok;
   logic sram_ok;

   assign nv_ok = (port == CWP_PORT_WB) ? transparent : 1'b1;
   assign sram_ok = (port == CWP_PORT_SCAN) ? 1'b1 :
                    (port == CWP_PORT_WB) ? 1'b0 : write;
   assign granted = (space == CWP_SPACE_NV) ? nv_ok : sram_ok;

endmodule : cwp_access
`default_nettype wire

//--- cwp_wakeup.sv
// Overview of operation
// - All configuration data received sets internal done, starting three-phase wake-up.
// - Phase one releases global output release, letting user I/O drive.
// - Inputs stay live; asserted set/reset blocks them from user flip-flops.
// - Phase two releases set/reset and write block together.
// - While set/reset is asserted, enabled flip-flops take their set/clear value.
// - While write block is asserted, every RAM write enable is overridden.
// - Final phase asserts done pin, open-drain when its function enabled.
// - Enabled done pin held low stalls wake-up until seen high.
// - Disabled done pin never stalls wake-up.
// - Right after final phase the device enters user mode.
// - User mode ends only on reconfig pin, refresh command, offline programming or power cycle.
// - Any reconfig trigger drives init status and done low, back to init.
// - Boundary-scan port reads and writes both spaces, offline or transparent.
// - SPI and I2C may access non-volatile fully, write SRAM, never read SRAM.
// - Internal bus gets non-volatile access only in transparent mode, no SRAM reads or writes.
// - Offline flash programming halts user mode; feature, config, user sectors.
// - Background programming keeps user mode; config and user sectors only.
// - Background image takes effect only after a refresh reloads SRAM.
`timescale 1ns/1ns
`default_nettype none
module cwp_wakeup
   import cwp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Configuration engine
   input wire logic cfg_data_complete,
   input wire logic refresh_cmd,
   input wire logic [1:0] flash_cmd,
   input wire logic flash_prog_done,
   input wire logic [2:0] flash_sector_req,
   input wire logic user_ff_d,
   input wire logic user_ff_we,
   input wire logic user_ff_init,
   input wire logic user_ram_we,
   // Pins
   input wire logic reconfig_request_n,
   input wire logic done_pin_in,
   output logic done_pin_out,
   output logic done_pin_oe,
   output logic init_status_n,
   // Global strobes
   output logic global_output_release,
   output logic global_set_reset,
   output logic global_write_block_n,
   output logic user_mode,
   output logic [2:0] flash_sector_en,
   output logic gated_ram_we,
   output logic user_ff_q
);

   cwp_state_e state_q;
   cwp_state_e state_d;
   logic [31:0] ctrl_q;
   logic done_int_q;
   logic bg_active_q;
   logic [1:0] acc_port_q;
   logic acc_space_q;
   logic acc_write_q;
   logic acc_granted_q;
   logic reconfig_sync_n;
   logic done_pin_sync;
   logic granted;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   cwp_sync u_sync_prog
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .async_in(reconfig_request_n),
      .sync_out(reconfig_sync_n)
   );

   cwp_sync u_sync_done
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .async_in(done_pin_in),
      .sync_out(done_pin_sync)
   );

   ////////////////////////////////////////////////////////////////////
   // Access check

   cwp_access u_access
   (
      .port(pwdata[CWP_ACC_PORT_LO +: 2]),
      .space(pwdata[CWP_ACC_SPACE]),
      .write(pwdata[CWP_ACC_WRITE]),
      .transparent(ctrl_q[CWP_CTRL_TRANSPARENT]),
      .granted(granted)
   );

   ////////////////////////////////////////////////////////////////////
   // Decoding

   logic done_en;
   logic trigger;
   logic apb_wr;
   logic apb_rd;
   logic hit_ctrl;
   logic hit_status;
   logic hit_access;
   logic hit_result;
   logic addr_ok;
   logic [31:0] rdata_mux;
   logic [31:0] status_word;
   logic [31:0] result_word;
   logic offline_go;
   logic bg_go;

   assign done_en = ctrl_q[CWP_CTRL_DONE_EN];
   // Pin is active low; power cycling is the async reset itself
   assign trigger = ~reconfig_sync_n | refresh_cmd;
   assign offline_go = (flash_cmd == CWP_CMD_OFFLINE);
   assign bg_go = (flash_cmd == CWP_CMD_BACKGROUND);

   assign hit_ctrl = (paddr == CWP_ADDR_CTRL);
   assign hit_status = (paddr == CWP_ADDR_STATUS);
   assign hit_access = (paddr == CWP_ADDR_ACCESS);
   assign hit_result = (paddr == CWP_ADDR_RESULT);
   assign addr_ok = hit_ctrl | hit_status | hit_access | hit_result;
   // Slave answers in the first access cycle, so pready is always high
   assign apb_wr = psel & penable & pwrite & clk_en & addr_ok;
   assign apb_rd = psel & ~penable & ~pwrite;

   assign status_word = {23'h0, done_int_q, init_status_n, bg_active_q,
                         (state_q == CWP_ST_PROGMODE), user_mode, 1'b0, state_q};
   assign result_word = {26'h0, acc_granted_q, acc_write_q, acc_space_q,
                         acc_port_q, 1'b0};
   assign rdata_mux = hit_ctrl ? ctrl_q :
                      hit_status ? status_word :
                      hit_result ? result_word : CWP_RDATA_ZERO;

   ////////////////////////////////////////////////////////////////////
   // Wake-up sequencer

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         CWP_ST_INIT:
            if (reconfig_sync_n)
               state_d = CWP_ST_CONFIG;
         CWP_ST_CONFIG:
            if (done_int_q)
               state_d = CWP_ST_WAKE1;
         CWP_ST_WAKE1:
            state_d = CWP_ST_WAKE2;
         CWP_ST_WAKE2:
            state_d = CWP_ST_WAKE3;
         CWP_ST_WAKE3:
            if (!done_en || done_pin_sync)
               state_d = CWP_ST_USERMODE;
         CWP_ST_USERMODE:
            if (trigger)
               state_d = CWP_ST_INIT;
            else if (offline_go)
               state_d = CWP_ST_PROGMODE;
         CWP_ST_PROGMODE:
            if (flash_prog_done)
               state_d = CWP_ST_USERMODE;
         default:
            state_d = CWP_ST_INIT;
      endcase
      if (trigger && state_q != CWP_ST_USERMODE && state_q != CWP_ST_INIT)
         state_d = CWP_ST_INIT;
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         state_q <= CWP_ST_INIT;
      else if (clk_en)
         state_q <= state_d;
   end

   // Internal done: set when all data arrives, cleared by re-init
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         done_int_q <= 1'b0;
      else if (clk_en)
      begin
         if (state_d == CWP_ST_INIT)
            done_int_q <= 1'b0;
         else if (cfg_data_complete && state_q == CWP_ST_CONFIG)
            done_int_q <= 1'b1;
      end
   end

   // Global strobes, all registered
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         global_output_release <= 1'b0;
         global_set_reset <= 1'b1;
         global_write_block_n <= 1'b0;
         done_pin_oe <= 1'b1;
         init_status_n <= 1'b0;
         user_mode <= 1'b0;
      end
      else if (clk_en)
      begin
         global_output_release <= (state_d >= CWP_ST_WAKE1) && (state_d != CWP_ST_PROGMODE);
         global_set_reset <= (state_d < CWP_ST_WAKE2) || (state_d == CWP_ST_PROGMODE);
         global_write_block_n <= (state_d >= CWP_ST_WAKE2) && (state_d != CWP_ST_PROGMODE);
         // Open drain: release only from the final phase on
         done_pin_oe <= (state_d < CWP_ST_WAKE3) || (state_d == CWP_ST_PROGMODE);
         init_status_n <= (state_d != CWP_ST_INIT);
         user_mode <= (state_d == CWP_ST_USERMODE);
      end
   end

   assign done_pin_out = 1'b0;

   ////////////////////////////////////////////////////////////////////
   // User logic gating

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         user_ff_q <= 1'b0;
         gated_ram_we <= 1'b0;
      end
      else if (clk_en)
      begin
         if (global_set_reset)
            user_ff_q <= user_ff_init;
         else if (user_ff_we)
            user_ff_q <= user_ff_d;
         gated_ram_we <= user_ram_we & global_write_block_n & ~global_set_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Flash programming

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         bg_active_q <= 1'b0;
         flash_sector_en <= 3'h0;
      end
      else if (clk_en)
      begin
         // A new start in the cycle of the old done wins; re-init always clears
         if (state_d == CWP_ST_INIT)
            bg_active_q <= 1'b0;
         else if (bg_go && state_q == CWP_ST_USERMODE)
            bg_active_q <= 1'b1;
         else if (flash_prog_done)
            bg_active_q <= 1'b0;
         if (state_d == CWP_ST_PROGMODE)
            flash_sector_en <= flash_sector_req;
         else if (bg_active_q || (bg_go && state_q == CWP_ST_USERMODE))
            flash_sector_en <= flash_sector_req & ~(3'h1 << CWP_SEC_FEATURE);
         else
            flash_sector_en <= 3'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // APB registers

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_q <= CWP_CTRL_RESET;
         acc_port_q <= 2'h0;
         acc_space_q <= 1'b0;
         acc_write_q <= 1'b0;
         acc_granted_q <= 1'b0;
      end
      else if (clk_en && apb_wr)
      begin
         if (hit_ctrl)
            ctrl_q <= {30'h0, pwdata[CWP_CTRL_TRANSPARENT:CWP_CTRL_DONE_EN]};
         if (hit_access && pwdata[CWP_ACC_GO])
         begin
            acc_port_q <= pwdata[CWP_ACC_PORT_LO +: 2];
            acc_space_q <= pwdata[CWP_ACC_SPACE];
            acc_write_q <= pwdata[CWP_ACC_WRITE];
            acc_granted_q <= granted;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         prdata <= CWP_RDATA_ZERO;
         pready <= 1'b1;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready <= 1'b1;
         if (psel && !penable)
         begin
            pslverr <= ~addr_ok;
            prdata <= apb_rd ? rdata_mux : CWP_RDATA_ZERO;
         end
      end
   end

endmodule : cwp_wakeup
`default_nettype wire

//--- cwp_wakeup_props.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_wakeup_props (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic global_output_release,
   input wire logic global_set_reset,
   input wire logic global_write_block_n,
   input wire logic done_pin_oe,
   input wire logic init_status_n,
   input wire logic user_mode,
   input wire logic refresh_cmd,
   input wire logic user_ff_d,
   input wire logic user_ff_we,
   input wire logic user_ff_init,
   input wire logic user_ff_q,
   input wire logic gated_ram_we
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   sequence s_held;
      global_set_reset && !global_write_block_n;
   endsequence
   sequence s_opened;
      !global_set_reset && global_write_block_n;
   endsequence
   // Offline return to user raises the strobes too, so key on a held set/reset
   property p_wake_order;
      $rose(global_output_release) ##0 s_held |-> ##1 s_opened ##1 !done_pin_oe;
   endproperty
   property p_release_pair;
      $fell(global_set_reset) && !user_mode |-> $rose(global_write_block_n);
   endproperty
   property p_user_entry;
      $rose(user_mode) && !$past(global_set_reset) |-> !done_pin_oe && !$past(done_pin_oe);
   endproperty
   property p_user_open;
      user_mode |-> global_output_release ##0 s_opened;
   endproperty
   property p_trigger_pins;
      $fell(init_status_n) |-> done_pin_oe && !user_mode && global_set_reset;
   endproperty
   property p_refresh_exit;
      clk_en && user_mode && refresh_cmd |=> !init_status_n && done_pin_oe;
   endproperty
   property p_ff_forced;
      clk_en && global_set_reset ##1 global_set_reset |-> user_ff_q == $past(user_ff_init);
   endproperty
   property p_ff_live;
      clk_en && !global_set_reset && user_ff_we ##1 !global_set_reset |-> user_ff_q == $past(user_ff_d);
   endproperty
   property p_ram_blocked;
      clk_en && !global_write_block_n ##1 !global_write_block_n |-> !gated_ram_we;
   endproperty
   a_wake_order: assert property (p_wake_order) else $error("wake order");
   a_release_pair: assert property (p_release_pair) else $error("release pair");
   a_user_entry: assert property (p_user_entry) else $error("user entry");
   a_user_open: assert property (p_user_open) else $error("user strobes");
   a_trigger_pins: assert property (p_trigger_pins) else $error("trigger pins");
   a_refresh_exit: assert property (p_refresh_exit) else $error("refresh exit");
   a_ff_forced: assert property (p_ff_forced) else $error("ff not forced");
   a_ff_live: assert property (p_ff_live) else $error("ff input lost");
   a_ram_blocked: assert property (p_ram_blocked) else $error("ram write leaked");
endmodule : cwp_wakeup_props
bind cwp_wakeup cwp_wakeup_props u_props (
   .ref_clk, .reset, .clk_en, .global_output_release, .global_set_reset, .global_write_block_n, .done_pin_oe,
   .init_status_n, .user_mode, .refresh_cmd, .user_ff_d, .user_ff_we, .user_ff_init, .user_ff_q, .gated_ram_we
);
`default_nettype wire

//--- cwp_partner.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_partner (
   input wire logic ref_clk,
   input wire logic done_pin_oe,
   input wire logic done_pin_out,
   input wire logic hold_done,
   input wire logic req_refresh,
   input wire logic req_reconfig,
   input wire logic user_mode,
   input wire logic [2:0] flash_sector_en,
   output logic done_pin_in,
   output logic refresh_cmd,
   output logic reconfig_request_n,
   output logic pll_right_hold
);
   // Right PLL kept in reset while flash is written behind running user logic
   assign pll_right_hold = user_mode && (flash_sector_en != 3'h0);
   // Pulled up; low whenever either side pulls
   assign done_pin_in = !((done_pin_oe && !done_pin_out) || hold_done);
   // Never two trigger sources at once: the pin wins
   always @(posedge ref_clk)
   begin
      refresh_cmd <= req_refresh && !req_reconfig;
      reconfig_request_n <= !req_reconfig;
   end
endmodule : cwp_partner
`default_nettype wire

//--- cwp_wakeup_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cwp_wakeup_tb import cwp_pkg::*;;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} cwp_note_s;
   logic ref_clk, reset, clk_en, psel, penable, pwrite, pready, pslverr, cfg_data_complete, refresh_cmd;
   logic flash_prog_done, user_ff_d, user_ff_we, user_ff_init, user_ram_we, user_ff_q, gated_ram_we;
   logic reconfig_request_n, done_pin_in, done_pin_out, done_pin_oe, init_status_n, user_mode;
   logic global_output_release, global_set_reset, global_write_block_n, hold_done, req_refresh, req_reconfig;
   logic pll_right_hold;
   logic [1:0] flash_cmd;
   logic [2:0] flash_sector_req, flash_sector_en;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   cwp_note_s notes[$];
   cwp_note_s note;
   int bad_count = 0;
   int checks_done = 0;
   int i;
   cwp_wakeup dut (
      .ref_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cfg_data_complete, .refresh_cmd, .flash_cmd, .flash_prog_done, .flash_sector_req, .user_ff_d,
      .user_ff_we, .user_ff_init, .user_ram_we, .reconfig_request_n, .done_pin_in, .done_pin_out,
      .done_pin_oe, .init_status_n, .global_output_release, .global_set_reset, .global_write_block_n,
      .user_mode, .flash_sector_en, .gated_ram_we, .user_ff_q
   );
   cwp_partner far_end (
      .ref_clk, .done_pin_oe, .done_pin_out, .hold_done, .req_refresh, .req_reconfig, .done_pin_in,
      .refresh_cmd, .reconfig_request_n, .user_mode, .flash_sector_en, .pll_right_hold
   );
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      {user_ff_d, user_ff_we, user_ff_init, user_ram_we} <= 4'($urandom);
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang();
      bad_count++;
      test_done();
   endtask : hang
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge ref_clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
         hang();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
      notes.push_back('{d, m, e});
      apb(1'b0, a, CWP_RDATA_ZERO);
   endtask : rd
   // Sampled at the falling edge, returns aligned to a rising edge
   task automatic wait_until(input int sel, input logic v);
      int n;
      for (n = 0; n < 200; n++)
      begin
         @(negedge ref_clk);
         if ((sel == 0 ? done_pin_oe : sel == 1 ? user_mode : init_status_n) === v)
            break;
         @(posedge ref_clk);
      end
      if (n == 200)
         hang();
      @(posedge ref_clk);
   endtask : wait_until
   task automatic wake();
      cfg_data_complete <= 1'b1;
      wait_until(0, 1'b0);
      cfg_data_complete <= 1'b0;
   endtask : wake
   task automatic pulse(input int sel);
      {req_refresh, flash_prog_done} <= sel == 0 ? 2'b10 : 2'b01;
      @(posedge ref_clk);
      {req_refresh, flash_prog_done} <= 2'b00;
   endtask : pulse
   function automatic logic grant(input logic [1:0] p, input logic s, input logic w, input logic t);
      if (p == CWP_PORT_SCAN)
         return 1'b1;
      if (p == CWP_PORT_WB)
         return s == CWP_SPACE_NV && t;
      return w || s == CWP_SPACE_NV;
   endfunction : grant
   always @(posedge ref_clk)
   begin
      if (psel && penable && pready && !pwrite)
      begin
         note = notes.pop_front();
         chk(prdata & note.m, note.d & note.m);
         chk({31'h0, pslverr}, {31'h0, note.e});
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(97663));
      {ref_clk, clk_en, reset, psel, penable, pwrite, cfg_data_complete, hold_done} = 8'h60;
      {flash_prog_done, req_refresh, req_reconfig} = 3'h0;
      {paddr, pwdata, flash_cmd, flash_sector_req} = 45'h0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rd(CWP_ADDR_CTRL, CWP_CTRL_RESET, 32'hFFFFFFFF, 1'b0);
      rd(8'h10, CWP_RDATA_ZERO, 32'hFFFFFFFF, 1'b1);
      for (i = 0; i < 32; i++)
      begin
         apb(1'b1, CWP_ADDR_CTRL, {30'h0, i[4], 1'b1});
         apb(1'b1, CWP_ADDR_ACCESS, {26'h0, i[4], 1'b1, i[3:0]});
         rd(CWP_ADDR_RESULT, {26'h0, grant(i[1:0], i[2], i[3], i[4]), 5'h0}, 32'h20, 1'b0);
      end
      hold_done <= 1'b1;
      wake();
      repeat (20) @(posedge ref_clk);
      chk({31'h0, user_mode}, 32'h0);
      hold_done <= 1'b0;
      wait_until(1, 1'b1);
      chk({29'h0, global_output_release, global_set_reset, global_write_block_n}, 32'h5);
      rd(CWP_ADDR_STATUS, {23'h0, 1'b1, 1'b1, 2'b00, 1'b1, 1'b0, CWP_ST_USERMODE}, 32'hFFFFFFFF, 1'b0);
      // Frozen block must ignore a refresh that arrives while clk_en is low
      clk_en <= 1'b0;
      pulse(0);
      repeat (3) @(posedge ref_clk);
      chk({31'h0, user_mode}, 32'h1);
      clk_en <= 1'b1;
      @(posedge ref_clk);
      flash_sector_req <= 3'b111;
      flash_cmd <= CWP_CMD_OFFLINE;
      @(posedge ref_clk);
      flash_cmd <= CWP_CMD_NONE;
      wait_until(1, 1'b0);
      repeat (2) @(posedge ref_clk);
      chk({29'h0, flash_sector_en}, 32'h7);
      pulse(1);
      wait_until(1, 1'b1);
      flash_cmd <= CWP_CMD_BACKGROUND;
      @(posedge ref_clk);
      flash_cmd <= CWP_CMD_NONE;
      repeat (3) @(posedge ref_clk);
      chk({27'h0, pll_right_hold, user_mode, flash_sector_en}, 32'h1E);
      pulse(1);
      repeat (3) @(posedge ref_clk);
      chk({30'h0, user_mode, pll_right_hold}, 32'h2);
      pulse(0);
      wait_until(2, 1'b0);
      chk({30'h0, done_pin_oe, user_mode}, 32'h2);
      apb(1'b1, CWP_ADDR_CTRL, 32'h0);
      hold_done <= 1'b1;
      repeat (5) @(posedge ref_clk);
      wake();
      wait_until(1, 1'b1);
      hold_done <= 1'b0;
      req_reconfig <= 1'b1;
      wait_until(2, 1'b0);
      chk({30'h0, done_pin_oe, user_mode}, 32'h2);
      req_reconfig <= 1'b0;
      repeat (5) @(posedge ref_clk);
      test_done();
   end
endmodule : cwp_wakeup_tb
`default_nettype wire
